// ==== logic/mpio_map.vh ====
// Register indices, field layouts, reset values and constants of the parallel I/O block
`ifndef MPIO_MAP_VH
`define MPIO_MAP_VH

// ***************************************************************
// Register indices (byte address is four times the index)
// ***************************************************************
`define MPIO_IDX_P7_PINS 16'hffce
`define MPIO_IDX_P8_DIR 16'hffcd
`define MPIO_IDX_P8_DATA 16'hffcf
`define MPIO_IDX_P9_DIR 16'hffd0
`define MPIO_IDX_P9_DATA 16'hffd2
`define MPIO_IDX_REFRESH_CTRL 16'hffd4

// ***************************************************************
// Field widths and positions
// ***************************************************************
`define MPIO_P7_WIDTH 8
`define MPIO_P8_WIDTH 5
`define MPIO_P9_WIDTH 6
`define MPIO_REG_WIDTH 8
`define MPIO_REFRESH_EN_BIT 0
`define MPIO_P8_PLAIN_BIT 0

// ***************************************************************
// Reset values and fixed read patterns
// ***************************************************************
`define MPIO_P8_DIR_RESET 8'hf0
`define MPIO_P8_DATA_RESET 8'he0
`define MPIO_P9_DIR_RESET 8'hc0
`define MPIO_P9_DATA_RESET 8'hc0
`define MPIO_DIR_READ 8'hff
`define MPIO_P8_FIXED_ONES 8'he0
`define MPIO_P9_FIXED_ONES 8'hc0
`define MPIO_REFRESH_CTRL_RESET 8'h00

// ***************************************************************
// Synchroniser depth
// ***************************************************************
`define MPIO_SYNC_STAGES 2

`endif

// ==== logic/mpio_sync.v ====
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none

module mpio_sync #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // ***************************************************************
  // Capture stages
  // ***************************************************************
  reg [WIDTH-1:0] stage_a;
  reg [WIDTH-1:0] stage_b;

  // First stage feeds only the second; nothing else looks at it
  always @(posedge mclk) begin
    if (rst) begin
      stage_a <= {WIDTH{1'b0}};
      stage_b <= {WIDTH{1'b0}};
    end else begin
      stage_a <= async_in;
      stage_b <= stage_a;
    end
  end

  assign sync_out = stage_b;

endmodule // mpio_sync

`default_nettype wire

// ==== logic/mpio_top.v ====
// Parallel I/O for the input-only port 7 and the shared ports 8 and 9, APB register access
//
// Contract
// - Port 7 reads always return the current pin levels; nothing stored.
// - Port 8 direction 1: pins 4..1 drive chip selects 0..3, pin 0 plain output.
// - Direction registers of ports 8 and 9 are write-only and read all ones.
// - Port 8 direction loads f0 on reset and hardware standby.
// - Port 9 direction loads c0 on reset and hardware standby.
// - Software standby keeps registers; pins set as outputs keep driving.
// - Data reads give stored bit for outputs, live pin level for inputs.
// - Port 8 data bits 7..5 ignore writes and read as one.
// - Port 9 data bits 7..6 ignore writes and read as one.
// - Port 8 data loads e0 on reset and hardware standby; kept in standby.
// - Port 9 data loads c0 on reset and hardware standby; kept in standby.
// - Port 8 pins 3..0 always feed interrupt request inputs 3..0.
// - Port 9 pin is output when direction 1, input when 0.
// - Pin function selection is the same in every operating mode.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mpio_map.vh"

module mpio_top #(
  parameter P7_WIDTH = `MPIO_P7_WIDTH,
  parameter P8_WIDTH = `MPIO_P8_WIDTH,
  parameter P9_WIDTH = `MPIO_P9_WIDTH
) (
  input wire mclk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Power states
  input wire hw_standby,
  input wire sw_standby,
  // Strobes from the bus and refresh controllers, active low
  input wire [3:0] chip_select_strobe_n,
  input wire refresh_strobe_n,
  // Port 7 pins
  input wire [P7_WIDTH-1:0] port7_pin_in,
  // Port 8 pins
  input wire [P8_WIDTH-1:0] port8_pin_in,
  output reg [P8_WIDTH-1:0] port8_pin_out,
  output reg [P8_WIDTH-1:0] port8_pin_oe,
  // Port 9 pins
  input wire [P9_WIDTH-1:0] port9_pin_in,
  output reg [P9_WIDTH-1:0] port9_pin_out,
  output reg [P9_WIDTH-1:0] port9_pin_oe,
  // Interrupt request inputs 5..0 taken from pin levels, active low
  output wire [5:0] interrupt_request_in_n
);

  // ***************************************************************
  // Register storage
  // ***************************************************************
  reg [P8_WIDTH-1:0] port8_direction;
  reg [P8_WIDTH-1:0] port8_output_data;
  reg [P9_WIDTH-1:0] port9_direction;
  reg [P9_WIDTH-1:0] port9_output_data;
  reg refresh_output_enable;

  // Reset patterns at full register width; only the pin bits are stored.
  // Port 8 pin 4 leaves reset as an output, so its chip select drives at once.
  localparam [7:0] P8_DIR_RST = `MPIO_P8_DIR_RESET;
  localparam [7:0] P8_DATA_RST = `MPIO_P8_DATA_RESET;
  localparam [7:0] P9_DIR_RST = `MPIO_P9_DIR_RESET;
  localparam [7:0] P9_DATA_RST = `MPIO_P9_DATA_RESET;
  localparam [7:0] REFRESH_CTRL_RST = `MPIO_REFRESH_CTRL_RESET;

  // Synchronised pin levels
  wire [P7_WIDTH-1:0] port7_pin_levels;
  wire [P8_WIDTH-1:0] port8_pin_levels;
  wire [P9_WIDTH-1:0] port9_pin_levels;

  // Bus decode
  wire [15:0] reg_index;
  wire setup_phase;
  wire access_phase;
  wire write_strobe;
  wire hit_p7;
  wire hit_p8_dir;
  wire hit_p8_data;
  wire hit_p9_dir;
  wire hit_p9_data;
  wire hit_refresh;
  wire hit_any;
  wire clear_regs;

  reg [31:0] next_prdata;
  reg [P8_WIDTH-1:0] next_port8_out;
  reg [P8_WIDTH-1:0] next_port8_oe;

  // ***************************************************************
  // Functions
  // ***************************************************************

  // Index of a word-aligned byte address
  function [15:0] word_index;
    input [17:0] addr;
    begin
      word_index = addr[17:2];
    end
  endfunction

  // Output bits show stored data, input bits show the pin
  function [7:0] merge_read;
    input [7:0] dir;
    input [7:0] data;
    input [7:0] pins;
    input [7:0] fixed_ones;
    begin
      merge_read = ((dir & data) | (~dir & pins)) | fixed_ones;
    end
  endfunction

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************

  // Pins are slow to the core clock; two flops keep reads and IRQs clean
  mpio_sync #(
    .WIDTH(P7_WIDTH)
  ) u_sync_p7 (
    .mclk(mclk),
    .rst(rst),
    .async_in(port7_pin_in),
    .sync_out(port7_pin_levels)
  );

  mpio_sync #(
    .WIDTH(P8_WIDTH)
  ) u_sync_p8 (
    .mclk(mclk),
    .rst(rst),
    .async_in(port8_pin_in),
    .sync_out(port8_pin_levels)
  );

  mpio_sync #(
    .WIDTH(P9_WIDTH)
  ) u_sync_p9 (
    .mclk(mclk),
    .rst(rst),
    .async_in(port9_pin_in),
    .sync_out(port9_pin_levels)
  );

  // ***************************************************************
  // APB decode
  // ***************************************************************

  // Misaligned addresses never hit, so they answer with an error
  assign reg_index = word_index(paddr);
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_p7 = (paddr[1:0] == 2'h0) && (reg_index == `MPIO_IDX_P7_PINS);
  assign hit_p8_dir = (paddr[1:0] == 2'h0) && (reg_index == `MPIO_IDX_P8_DIR);
  assign hit_p8_data = (paddr[1:0] == 2'h0) && (reg_index == `MPIO_IDX_P8_DATA);
  assign hit_p9_dir = (paddr[1:0] == 2'h0) && (reg_index == `MPIO_IDX_P9_DIR);
  assign hit_p9_data = (paddr[1:0] == 2'h0) && (reg_index == `MPIO_IDX_P9_DATA);
  assign hit_refresh = (paddr[1:0] == 2'h0) && (reg_index == `MPIO_IDX_REFRESH_CTRL);
  assign hit_any = hit_p7 | hit_p8_dir | hit_p8_data | hit_p9_dir | hit_p9_data | hit_refresh;

  // Zero wait states: read data is caught in the setup cycle
  assign pready = access_phase;
  assign pslverr = access_phase & (~hit_any | (pwrite & hit_p7));

  // Writes are frozen in software standby since the core is asleep there
  assign write_strobe = access_phase & pwrite & ~sw_standby;
  assign clear_regs = rst | hw_standby;

  // ***************************************************************
  // Read data path
  // ***************************************************************

  // Read word, built in the setup cycle and held through the access
  always @* begin
    next_prdata = 32'h0000_0000;
    if (hit_p7) begin
      next_prdata[7:0] = port7_pin_levels;
    end else if (hit_p8_dir | hit_p9_dir) begin
      next_prdata[7:0] = `MPIO_DIR_READ;
    end else if (hit_p8_data) begin
      next_prdata[7:0] = merge_read({3'h0, port8_direction},
                                    {3'h0, port8_output_data},
                                    {3'h0, port8_pin_levels},
                                    `MPIO_P8_FIXED_ONES);
    end else if (hit_p9_data) begin
      next_prdata[7:0] = merge_read({2'h0, port9_direction},
                                    {2'h0, port9_output_data},
                                    {2'h0, port9_pin_levels},
                                    `MPIO_P9_FIXED_ONES);
    end else if (hit_refresh) begin
      next_prdata[`MPIO_REFRESH_EN_BIT] = refresh_output_enable;
    end
  end

  // Read data register
  always @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ***************************************************************
  // Port 8 registers
  // ***************************************************************

  // Upper bits are not stored, so writes to them are lost
  always @(posedge mclk) begin
    if (clear_regs) begin
      port8_direction <= P8_DIR_RST[P8_WIDTH-1:0];
      port8_output_data <= P8_DATA_RST[P8_WIDTH-1:0];
    end else begin
      if (write_strobe & hit_p8_dir) begin
        port8_direction <= pwdata[P8_WIDTH-1:0];
      end
      if (write_strobe & hit_p8_data) begin
        port8_output_data <= pwdata[P8_WIDTH-1:0];
      end
    end
  end

  // ***************************************************************
  // Port 9 registers
  // ***************************************************************

  // Same scheme as port 8; software standby simply holds the value
  always @(posedge mclk) begin
    if (clear_regs) begin
      port9_direction <= P9_DIR_RST[P9_WIDTH-1:0];
      port9_output_data <= P9_DATA_RST[P9_WIDTH-1:0];
    end else begin
      if (write_strobe & hit_p9_dir) begin
        port9_direction <= pwdata[P9_WIDTH-1:0];
      end
      if (write_strobe & hit_p9_data) begin
        port9_output_data <= pwdata[P9_WIDTH-1:0];
      end
    end
  end

  // ***************************************************************
  // Refresh control
  // ***************************************************************

  // Enable for the refresh strobe on port 8 pin 0
  always @(posedge mclk) begin
    if (clear_regs) begin
      refresh_output_enable <= REFRESH_CTRL_RST[`MPIO_REFRESH_EN_BIT];
    end else if (write_strobe & hit_refresh) begin
      refresh_output_enable <= pwdata[`MPIO_REFRESH_EN_BIT];
    end
  end

  // ***************************************************************
  // Port 8 pin function selection
  // ***************************************************************

  // No mode input exists: selection never looks at the chip mode
  always @* begin
    next_port8_out = {P8_WIDTH{1'b0}};
    next_port8_oe = port8_direction;
    // Chip selects wire in reverse order onto pins 4..1
    next_port8_out[4] = chip_select_strobe_n[0];
    next_port8_out[3] = chip_select_strobe_n[1];
    next_port8_out[2] = chip_select_strobe_n[2];
    next_port8_out[1] = chip_select_strobe_n[3];
    // Pin 0: refresh strobe overrides the direction bit
    if (refresh_output_enable) begin
      next_port8_out[0] = refresh_strobe_n;
      next_port8_oe[0] = 1'b1;
    end else begin
      next_port8_out[0] = port8_output_data[`MPIO_P8_PLAIN_BIT];
    end
  end

  // ***************************************************************
  // Pin drive flops
  // ***************************************************************

  // One registered stage after the register write; in software standby port 9 and
  // the port 8 enables hold, while port 8 outputs still follow the strobes
  always @(posedge mclk) begin
    if (clear_regs) begin
      port8_pin_out <= {P8_WIDTH{1'b0}};
      port8_pin_oe <= {P8_WIDTH{1'b0}};
      port9_pin_out <= {P9_WIDTH{1'b0}};
      port9_pin_oe <= {P9_WIDTH{1'b0}};
    end else begin
      port8_pin_out <= next_port8_out;
      port8_pin_oe <= next_port8_oe;
      port9_pin_out <= port9_output_data;
      port9_pin_oe <= port9_direction;
    end
  end

  // ***************************************************************
  // Interrupt request inputs
  // ***************************************************************

  // Pin levels feed the interrupt inputs whatever the pin drives
  assign interrupt_request_in_n[3:0] = port8_pin_levels[3:0];
  assign interrupt_request_in_n[5:4] = port9_pin_levels[5:4];

endmodule // mpio_top

`default_nettype wire

// ==== verif/mpio_checker_assertions.sv ====
// Concurrent checks on the parallel I/O block ports
`timescale 1ns/1ps
`default_nettype none
`include "mpio_map.vh"
// ****************
// Port checker
// ****************
module mpio_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [3:0] chip_select_strobe_n,
  input wire logic [4:0] port8_pin_in,
  input wire logic [4:0] port8_pin_out,
  input wire logic [4:0] port8_pin_oe,
  input wire logic [5:0] port9_pin_out,
  input wire logic [5:0] port9_pin_oe,
  input wire logic [5:0] interrupt_request_in_n
);
  // Pin enables right after reset follow the direction reset patterns
  localparam logic [7:0] P8_OE_RST = `MPIO_P8_DIR_RESET;
  localparam logic [7:0] P9_OE_RST = `MPIO_P9_DIR_RESET;
  logic [1:0] warm;
  logic [3:0] cs_q;
  // Sync flops hold cleared levels for two edges after rst; hw_standby does not clear them
  always @(posedge mclk) begin
    if (rst || hw_standby) begin
      warm <= 2'h0;
    end else if (warm != 2'h3) begin
      warm <= warm + 2'h1;
    end
  end
  // Strobes in pin order, one edge late as the block registers them
  always @(posedge mclk) begin
    cs_q <= {<<{chip_select_strobe_n}};
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst || hw_standby);
  sequence s_rd(a);
    psel && !penable && !pwrite && paddr == {a, 2'h0};
  endsequence
  sequence s_wr(a);
    psel && penable && pwrite && !sw_standby && paddr == {a, 2'h0};
  endsequence
  property p_dir_ones;
    s_rd(`MPIO_IDX_P8_DIR) or s_rd(`MPIO_IDX_P9_DIR) |=> prdata == 32'hff;
  endproperty
  a_dir_ones: assert property (p_dir_ones) else $error("direction read not ones");
  property p_p8_ones;
    s_rd(`MPIO_IDX_P8_DATA) |=> prdata[7:5] == 3'h7;
  endproperty
  a_p8_ones: assert property (p_p8_ones) else $error("port8 upper bits not ones");
  property p_p9_ones;
    s_rd(`MPIO_IDX_P9_DATA) |=> prdata[7:6] == 2'h3;
  endproperty
  a_p9_ones: assert property (p_p9_ones) else $error("port9 upper bits not ones");
  property p_p9_drive;
    s_wr(`MPIO_IDX_P9_DIR) |-> ##2 port9_pin_oe == $past(pwdata[5:0], 2);
  endproperty
  a_p9_drive: assert property (p_p9_drive) else $error("port9 enables off");
  property p_cs_route;
    !sw_standby && !$past(sw_standby) |-> ((port8_pin_out[4:1] ^ cs_q) & port8_pin_oe[4:1]) == 4'h0;
  endproperty
  a_cs_route: assert property (p_cs_route) else $error("strobe routing wrong");
  property p_hold;
    sw_standby [*2] |=> $stable(port9_pin_oe) && $stable(port9_pin_out) && $stable(port8_pin_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("pins moved in standby");
  property p_reset_off;
    $fell(rst) || $fell(hw_standby) |-> ##1 port8_pin_oe == P8_OE_RST[4:0] &&
      port9_pin_oe == P9_OE_RST[5:0];
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("pin enables not at reset values");
  property p_irq;
    warm >= 2'h2 |-> interrupt_request_in_n[3:0] == $past(port8_pin_in[3:0], 2);
  endproperty
  a_irq: assert property (p_irq) else $error("request inputs wrong");
endmodule // mpio_checker
bind mpio_top mpio_checker chk_u (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .hw_standby, .sw_standby, .chip_select_strobe_n, .port8_pin_in, .port8_pin_out,
  .port8_pin_oe, .port9_pin_out, .port9_pin_oe, .interrupt_request_in_n);
`default_nettype wire

// ==== verif/mpio_ext_model.sv ====
// Model of the external devices wired to the port 8 and port 9 pins
`timescale 1ns/1ps
`default_nettype none
// ****************
// Pin resolution
// ****************
module mpio_ext_model (
  input wire logic [4:0] port8_pin_out,
  input wire logic [4:0] port8_pin_oe,
  input wire logic [4:0] p8_ext,
  output logic [4:0] port8_pin_in,
  input wire logic [5:0] port9_pin_out,
  input wire logic [5:0] port9_pin_oe,
  input wire logic [5:0] p9_ext,
  output logic [5:0] port9_pin_in
);
  // A pin the block drives shows its level; elsewhere the far device drives, so nothing floats
  assign port8_pin_in = (port8_pin_out & port8_pin_oe) | (p8_ext & ~port8_pin_oe);
  assign port9_pin_in = (port9_pin_out & port9_pin_oe) | (p9_ext & ~port9_pin_oe);
endmodule // mpio_ext_model
`default_nettype wire

// ==== verif/tb_multi_port_parallel_io.sv ====
// Self-checking bench for the parallel I/O block
`timescale 1ns/1ps
`default_nettype none
`include "mpio_map.vh"
// ****************
// Bench
// ****************
module tb_multi_port_parallel_io;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic hw_standby = 1'b0, sw_standby = 1'b0, refresh_strobe_n = 1'b1, pready, pslverr, err;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  // Not a palindrome, so a pin order mix-up shows
  logic [3:0] chip_select_strobe_n = 4'h3;
  logic [7:0] port7_pin_in = 8'h5a;
  logic [4:0] port8_pin_in, port8_pin_out, port8_pin_oe, p8_ext = 5'h0a;
  logic [5:0] port9_pin_in, port9_pin_out, port9_pin_oe, interrupt_request_in_n, p9_ext = 6'h25;
  int num_errors = 0, checked = 0, cyc = 0;
  mpio_top dut_u (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .hw_standby, .sw_standby, .chip_select_strobe_n, .refresh_strobe_n,
    .port7_pin_in, .port8_pin_in, .port8_pin_out, .port8_pin_oe, .port9_pin_in,
    .port9_pin_out, .port9_pin_oe, .interrupt_request_in_n);
  mpio_ext_model ext_u (.port8_pin_out, .port8_pin_oe, .p8_ext, .port8_pin_in,
    .port9_pin_out, .port9_pin_oe, .p9_ext, .port9_pin_in);
  always #5 mclk = ~mclk;
  // Cut a hang short well past the hundred or so cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end
  task automatic results;
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; waits for pready, then keeps read data and error
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reset values, live pin reads and request inputs
  task automatic t_reset;
    chk("p8 oe rst", port8_pin_oe, 32'h10);
    chk("p8 out rst", port8_pin_out[4], 32'h1);
    chk("p9 oe rst", port9_pin_oe, 32'h0);
    apb(1'b0, `MPIO_IDX_P8_DIR, 32'h0);
    chk("p8 dir", rdv, 32'hff);
    apb(1'b0, `MPIO_IDX_P9_DIR, 32'h0);
    chk("p9 dir", rdv, 32'hff);
    apb(1'b0, `MPIO_IDX_P8_DATA, 32'h0);
    chk("p8 data", rdv, 32'hea);
    apb(1'b0, `MPIO_IDX_P9_DATA, 32'h0);
    chk("p9 data", rdv, 32'he5);
    chk("irq", interrupt_request_in_n, 32'h2a);
    @(posedge mclk);
    port7_pin_in <= 8'ha5;
    repeat (2) @(posedge mclk);
    apb(1'b0, `MPIO_IDX_P7_PINS, 32'h0);
    chk("p7 pins", rdv, 32'ha5);
    apb(1'b1, `MPIO_IDX_P7_PINS, 32'h0);
    chk("p7 write err", err, 32'h1);
    apb(1'b0, 16'h0100, 32'h0);
    chk("unmapped err", err, 32'h1);
  endtask
  // Port 9 outputs mixed with inputs; upper bits written as zero
  task automatic t_port9;
    apb(1'b1, `MPIO_IDX_P9_DATA, 32'h0a);
    apb(1'b1, `MPIO_IDX_P9_DIR, 32'h0f);
    @(posedge mclk);
    #1;
    chk("p9 oe", port9_pin_oe, 32'h0f);
    chk("p9 out", port9_pin_out[3:0], 32'ha);
    apb(1'b0, `MPIO_IDX_P9_DATA, 32'h0);
    chk("p9 mixed", rdv, 32'hea);
  endtask
  // Port 8 strobes land on pins 4..1 in reverse; pin 0 is plain output
  task automatic t_port8;
    apb(1'b1, `MPIO_IDX_P8_DATA, 32'h01);
    apb(1'b1, `MPIO_IDX_P8_DIR, 32'h1f);
    @(posedge mclk);
    #1;
    chk("p8 oe", port8_pin_oe, 32'h1f);
    chk("p8 out", port8_pin_out, 32'h19);
    apb(1'b0, `MPIO_IDX_P8_DATA, 32'h0);
    chk("p8 stored", rdv, 32'he1);
    chip_select_strobe_n <= 4'hc;
    @(posedge mclk);
    #1;
    chk("p8 cs follow", port8_pin_out, 32'h07);
  endtask
  // Refresh enable takes pin 0 even with its direction bit clear
  task automatic t_refresh;
    apb(1'b1, `MPIO_IDX_P8_DIR, 32'h0);
    apb(1'b1, `MPIO_IDX_REFRESH_CTRL, 32'h1);
    @(posedge mclk);
    refresh_strobe_n <= 1'b0;
    @(posedge mclk);
    #1;
    chk("refresh oe", port8_pin_oe, 32'h1);
    chk("refresh out", port8_pin_out[0], 32'h0);
    apb(1'b1, `MPIO_IDX_REFRESH_CTRL, 32'h0);
  endtask
  // Software standby freezes port 9 pins; hardware standby restores reset values
  task automatic t_standby;
    @(posedge mclk);
    sw_standby <= 1'b1;
    apb(1'b1, `MPIO_IDX_P9_DIR, 32'h0);
    apb(1'b1, `MPIO_IDX_P9_DATA, 32'h3f);
    @(posedge mclk);
    #1;
    chk("sw oe", port9_pin_oe, 32'h0f);
    chk("sw out", port9_pin_out[3:0], 32'ha);
    @(posedge mclk);
    sw_standby <= 1'b0;
    hw_standby <= 1'b1;
    @(posedge mclk);
    hw_standby <= 1'b0;
    repeat (3) @(posedge mclk);
    apb(1'b0, `MPIO_IDX_P9_DATA, 32'h0);
    chk("hw p9 data", rdv, 32'he5);
    chk("hw p9 oe", port9_pin_oe, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_reset();
    t_port9();
    t_port8();
    t_refresh();
    t_standby();
    results();
  end
endmodule // tb_multi_port_parallel_io
`default_nettype wire
